// [rtl/sit_consts.vh]
// constants for the serializer init and thermal ramp setup block
// Rules of the document behind this block
// R1 - host may release power-down right after the supply is stable
// R2 - host holds power-down high at least 1 ms before a hard reset
// R3 - hard reset holds power-down low at least 3 ms
// R4 - power-down low powers off and returns all registers to defaults
// R5 - synchronous mode locks onto back-channel reference clock when present
// R6 - synchronous mode forward link supports up to 4.16 Gbps
// R7 - sensor port takes one clock lane and one, two or four data lanes
// R8 - termination on shortly after high-speed entry, off after burst end
// R9 - host writes 0x12 to watchdog speed-up at 0x0a before remote access
// R10 - host sets analog 0x4c bits 6 to 4 to 0x7 by read-modify-write
// R11 - host sets bit 5 of analog 0x4b, adds offset, writes back
// R12 - offset by temperature code: 0-1 -1, 2-3 0, 4-6 1, 7 3
// R13 - temperature code comes from a 3-bit field in the deserializer
// R14 - indirect analog access: page 0xb0, offset 0xb1, data 0xb2
// R15 - writing 0x01 to 0x01 soft-resets and restarts link lock
// R16 - no control-bus answer until init after power-down release completes
`ifndef SIT_CONSTS_VH
`define SIT_CONSTS_VH
`define SIT_ADDR_SOFT_RESET 8'h01
`define SIT_ADDR_WDOG 8'h0a
`define SIT_ADDR_LANES 8'h20
`define SIT_ADDR_STATUS 8'h21
`define SIT_ADDR_PAGE 8'hb0
`define SIT_ADDR_OFFS 8'hb1
`define SIT_ADDR_DATA 8'hb2
`define SIT_ANA_PAGE 8'h04
`define SIT_ANA_ADAPT 8'h4b
`define SIT_ANA_FIXED 8'h4c
`define SIT_SOFT_RESET_CMD 8'h01
`define SIT_RST_WDOG 8'h00
`define SIT_RST_LANES 8'h04
`define SIT_RST_ANA_ADAPT 8'h00
`define SIT_RST_ANA_FIXED 8'h00
`define SIT_CLK_MHZ 200
`define SIT_INIT_MS 2
`define SIT_INIT_CYC (`SIT_INIT_MS * 1000 * `SIT_CLK_MHZ)
`define SIT_LOCK_US 10
`define SIT_LOCK_CYC (`SIT_LOCK_US * `SIT_CLK_MHZ)
`define SIT_TERM_NS 50
`define SIT_TERM_CYC ((`SIT_TERM_NS * `SIT_CLK_MHZ + 999) / 1000)
`endif

// [rtl/sit_sync2.v]
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sit_sync2 (
    input wire clk_sys_i,
    input wire rst_i,
    input wire d_i,
    output reg q_o
);
reg meta_reg;
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        meta_reg <= 1'b0;
        q_o <= 1'b0;
    end else begin
        meta_reg <= d_i;
        q_o <= meta_reg;
    end
end
endmodule

// [rtl/sit_top.v]
// power-up sequencer, register file, indirect analog window and lane termination
`timescale 1ns/1ps
`include "sit_consts.vh"
module sit_top #(
    parameter INIT_CYC = `SIT_INIT_CYC
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire power_down_n_input_i,
    input wire refclk_present_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire lane_lp_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_ack_o,
    output reg bus_ready_o,
    output reg link_locked_o,
    output reg term_en_o,
    output reg [3:0] lane_en_o,
    output reg [7:0] wdog_cfg_o,
    output reg [7:0] ana_adapt_o,
    output reg [7:0] ana_fixed_o
);
// ----------------------------------------
// pin synchronisers
// ----------------------------------------
wire pdn_s;
wire refclk_s;
wire lp_s;
sit_sync2 u_sync_pdn (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .d_i(power_down_n_input_i),
    .q_o(pdn_s));
sit_sync2 u_sync_ref (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .d_i(refclk_present_i),
    .q_o(refclk_s));
sit_sync2 u_sync_lp (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .d_i(lane_lp_i), .q_o(lp_s));

// ----------------------------------------
// power sequencer
// ----------------------------------------
localparam [3:0] ST_OFF = 4'b0001;
localparam [3:0] ST_INIT = 4'b0010;
localparam [3:0] ST_LOCK = 4'b0100;
localparam [3:0] ST_RUN = 4'b1000;
localparam [31:0] LOCK_CYC_W = `SIT_LOCK_CYC;
localparam [31:0] INIT_LAST_W = INIT_CYC - 1;
localparam [23:0] LOCK_CYC = LOCK_CYC_W[23:0];
localparam [23:0] INIT_LAST = INIT_LAST_W[23:0];
reg [3:0] st_reg;
reg [3:0] st_next;
reg [23:0] cnt_reg;
reg [23:0] cnt_next;
// a synchronised low power-down pin resets like rst_i, except the pin synchronisers
wire pwr_off = rst_i | ~pdn_s;
// soft reset keeps the registers and restarts only the lock search
wire soft_rst = reg_wr_i & bus_ready_o & (reg_addr_i == `SIT_ADDR_SOFT_RESET) &
    (reg_wdata_i == `SIT_SOFT_RESET_CMD);

always @* begin
    st_next = st_reg;
    cnt_next = cnt_reg + 24'h000001;
    case (st_reg)
        ST_OFF: begin
            cnt_next = 24'h000000;
            if (pdn_s) begin
                st_next = ST_INIT;
            end
        end
        ST_INIT: begin
            if (cnt_reg >= INIT_LAST) begin // [R16]
                st_next = ST_LOCK;
                cnt_next = 24'h000000;
            end
        end
        ST_LOCK: begin
            // lock needs the reference present for LOCK_CYC cycles in a row
            if (!refclk_s) begin // [R5]
                cnt_next = 24'h000000;
            end else if (cnt_reg >= LOCK_CYC - 24'h000001) begin
                st_next = ST_RUN;
                cnt_next = 24'h000000;
            end
        end
        ST_RUN: begin
            cnt_next = 24'h000000;
            if (!refclk_s) begin // [R5]
                st_next = ST_LOCK;
            end
        end
        default: begin
            st_next = ST_OFF;
            cnt_next = 24'h000000;
        end
    endcase
    if (soft_rst && (st_reg == ST_RUN || st_reg == ST_LOCK)) begin // [R15]
        st_next = ST_LOCK;
        cnt_next = 24'h000000;
    end
end

always @(posedge clk_sys_i) begin
    if (pwr_off) begin // [R4]
        st_reg <= ST_OFF;
        cnt_reg <= 24'h000000;
    end else begin
        st_reg <= st_next;
        cnt_reg <= cnt_next;
    end
end

// ----------------------------------------
// register file and indirect window
// ----------------------------------------
reg [7:0] page_reg;
reg [7:0] offs_reg;
reg [7:0] lanes_reg;
wire ana_sel = (page_reg == `SIT_ANA_PAGE);
reg [7:0] rd_val;

always @* begin
    rd_val = 8'h00;
    case (reg_addr_i)
        `SIT_ADDR_SOFT_RESET: rd_val = 8'h00;
        `SIT_ADDR_WDOG: rd_val = wdog_cfg_o;
        `SIT_ADDR_LANES: rd_val = lanes_reg;
        `SIT_ADDR_STATUS: rd_val = {6'h00, term_en_o, link_locked_o};
        `SIT_ADDR_PAGE: rd_val = page_reg;
        `SIT_ADDR_OFFS: rd_val = offs_reg;
        `SIT_ADDR_DATA: begin // [R14]
            if (ana_sel && offs_reg == `SIT_ANA_ADAPT) begin
                rd_val = ana_adapt_o;
            end else if (ana_sel && offs_reg == `SIT_ANA_FIXED) begin
                rd_val = ana_fixed_o;
            end else begin
                rd_val = 8'h00;
            end
        end
        default: rd_val = 8'h00;
    endcase
end

always @(posedge clk_sys_i) begin
    if (pwr_off) begin // [R4]
        wdog_cfg_o <= `SIT_RST_WDOG;
        lanes_reg <= `SIT_RST_LANES;
        page_reg <= 8'h00;
        offs_reg <= 8'h00;
        ana_adapt_o <= `SIT_RST_ANA_ADAPT;
        ana_fixed_o <= `SIT_RST_ANA_FIXED;
        reg_rdata_o <= 8'h00;
        reg_ack_o <= 1'b0;
    end else begin
        // accesses before bus_ready_o are dropped with no ack
        reg_ack_o <= bus_ready_o & (reg_wr_i | reg_rd_i); // [R16]
        reg_rdata_o <= (bus_ready_o & reg_rd_i) ? rd_val : 8'h00;
        if (bus_ready_o && reg_wr_i) begin
            case (reg_addr_i)
                `SIT_ADDR_WDOG: wdog_cfg_o <= reg_wdata_i;
                `SIT_ADDR_LANES: begin // [R7]
                    if (reg_wdata_i == 8'h01 || reg_wdata_i == 8'h02 ||
                        reg_wdata_i == 8'h04) begin
                        lanes_reg <= reg_wdata_i;
                    end
                end
                `SIT_ADDR_PAGE: page_reg <= reg_wdata_i; // [R14]
                `SIT_ADDR_OFFS: offs_reg <= reg_wdata_i; // [R14]
                `SIT_ADDR_DATA: begin // [R14]
                    if (ana_sel && offs_reg == `SIT_ANA_ADAPT) begin
                        ana_adapt_o <= reg_wdata_i;
                    end else if (ana_sel && offs_reg == `SIT_ANA_FIXED) begin
                        ana_fixed_o <= reg_wdata_i;
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

// ----------------------------------------
// status outputs, lanes and termination
// ----------------------------------------
localparam [31:0] TERM_CYC_W = `SIT_TERM_CYC;
localparam [7:0] TERM_CYC = TERM_CYC_W[7:0];
reg [7:0] term_cnt_reg;
reg lp_d_reg;

always @(posedge clk_sys_i) begin
    if (pwr_off) begin
        bus_ready_o <= 1'b0;
        link_locked_o <= 1'b0;
        lane_en_o <= 4'h0;
        term_en_o <= 1'b0;
        term_cnt_reg <= 8'h00;
        lp_d_reg <= 1'b1;
    end else begin
        bus_ready_o <= (st_next == ST_LOCK) | (st_next == ST_RUN); // [R16]
        link_locked_o <= (st_next == ST_RUN); // [R5] [R6]
        // lane enables follow the stored lane count one cycle later
        case (lanes_reg) // [R7]
            8'h01: lane_en_o <= 4'h1;
            8'h02: lane_en_o <= 4'h3;
            default: lane_en_o <= 4'hf;
        endcase
        // termination counts from the first high-speed cycle, drops at once on low power
        lp_d_reg <= lp_s;
        if (lp_s) begin // [R8]
            term_en_o <= 1'b0;
            term_cnt_reg <= 8'h00;
        end else if (lp_d_reg) begin
            term_cnt_reg <= 8'h01;
        end else if (term_cnt_reg != 8'h00 && !term_en_o) begin
            if (term_cnt_reg >= TERM_CYC) begin // [R8]
                term_en_o <= 1'b1;
            end else begin
                term_cnt_reg <= term_cnt_reg + 8'h01;
            end
        end
    end
end
endmodule

// [dv/sit_deser_model.sv]
// far-side model: back-channel reference and die temperature code
`timescale 1ns/1ps
module sit_deser_model #(parameter logic [2:0] TEMP_CODE = 3'h7) (
    input wire clk_sys_i,
    input wire link_up_i,
    output logic refclk_present_o,
    output wire [2:0] temp_code_o,
    output logic signed [3:0] offset_o
);
assign temp_code_o = TEMP_CODE;
always @(posedge clk_sys_i) refclk_present_o <= link_up_i;
always @* begin
    case (temp_code_o)
        3'h0, 3'h1: offset_o = -4'sd1;
        3'h2, 3'h3: offset_o = 4'sd0;
        3'h7: offset_o = 4'sd3;
        default: offset_o = 4'sd1;
    endcase
end
endmodule

// [dv/sit_chk.sv]
// assertions on the init sequencer ports
`timescale 1ns/1ps
module sit_chk #(parameter INIT_CYC = 20) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire power_down_n_input_i,
    input wire refclk_present_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire lane_lp_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_ack_o,
    input wire bus_ready_o,
    input wire link_locked_o,
    input wire term_en_o,
    input wire [3:0] lane_en_o,
    input wire [7:0] wdog_cfg_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
// cycles that the power-down pin has stood high since reset or its last rise, whichever is later
logic [31:0] up_cnt;
always @(posedge clk_sys_i) begin
    if (rst_i || !power_down_n_input_i) begin
        up_cnt <= 32'h0;
    end else if (up_cnt != 32'hffffffff) begin
        up_cnt <= up_cnt + 32'h1;
    end
end
sequence s_soft;
    bus_ready_o && reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i == 8'h01;
endsequence
sequence s_hs;
    lane_lp_i [*5] ##1 !lane_lp_i;
endsequence
a_no_early_ack: assert property (!bus_ready_o && (reg_wr_i || reg_rd_i) |=> !reg_ack_o)
    else $error("ack before bus ready");
a_ack_next: assert property (bus_ready_o && (reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("access not acked");
a_rdata_idle: assert property (!reg_ack_o |-> reg_rdata_o == 8'h00)
    else $error("read data outside ack");
a_pdn_clears: assert property (!power_down_n_input_i [*5] |->
    !bus_ready_o && wdog_cfg_o == 8'h00)
    else $error("power down kept state");
a_soft_unlock: assert property (s_soft |=> !link_locked_o [*3])
    else $error("lock kept after soft reset");
a_lock_lost: assert property (!refclk_present_i [*5] |-> !link_locked_o)
    else $error("locked without reference");
a_term_wait: assert property (s_hs |=> !term_en_o [*8])
    else $error("termination too early");
a_term_off: assert property (lane_lp_i [*5] |=> !term_en_o)
    else $error("termination left on");
a_wdog_store: assert property (bus_ready_o && reg_wr_i && reg_addr_i == 8'h0a |=>
    wdog_cfg_o == $past(reg_wdata_i))
    else $error("watchdog write lost");
a_lane_legal: assert property (lane_en_o inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("illegal lane set");
a_init_wait: assert property ($rose(bus_ready_o) |-> up_cnt >= INIT_CYC)
    else $error("bus ready before init time");
endmodule
bind sit_top sit_chk #(.INIT_CYC(INIT_CYC)) i_sit_chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .power_down_n_input_i(power_down_n_input_i),
    .refclk_present_i(refclk_present_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .lane_lp_i(lane_lp_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o),
    .bus_ready_o(bus_ready_o),
    .link_locked_o(link_locked_o),
    .term_en_o(term_en_o),
    .lane_en_o(lane_en_o),
    .wdog_cfg_o(wdog_cfg_o)
);

// [dv/tb_sit_top.sv]
// bench for the init sequencer
`timescale 1ns/1ps
module tb_sit_top;
logic clk_sys_i = 0, rst_i = 1, pdn = 1, lp = 1, wr = 0, rd = 0, bc_up = 0;
logic [7:0] addr = 0, wd = 0, rdat, ad;
logic [3:0] lane_exp [3] = '{4'h1, 4'h3, 4'hf};
wire [7:0] rdata, wdog, adapt, fixed;
wire ack, ready, locked, term, refclk;
wire [3:0] lanes;
wire signed [3:0] toff;
int n_fail = 0, n_compared = 0, n;
// scaled time: 10 cycles stand for 1 ms, as INIT_CYC of 20 stands for 2 ms
localparam int MS_CYC = 10;
always #2.5 clk_sys_i = ~clk_sys_i;
sit_top #(.INIT_CYC(20)) i_sit_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .power_down_n_input_i(pdn), .refclk_present_i(refclk), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .lane_lp_i(lp), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .bus_ready_o(ready), .link_locked_o(locked), .term_en_o(term), .lane_en_o(lanes),
    .wdog_cfg_o(wdog), .ana_adapt_o(adapt), .ana_fixed_o(fixed));
sit_deser_model i_sit_deser_model (.clk_sys_i(clk_sys_i), .link_up_i(bc_up),
    .refclk_present_o(refclk), .temp_code_o(), .offset_o(toff));
// ------------------------------
// tasks
// ------------------------------
task ck(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
        n_fail++;
        $display("Error %0t %s", $time, m);
    end
endtask
task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic e);
    @(negedge clk_sys_i);
    {wr, rd, addr, wd} = {w, !w, a, d};
    @(negedge clk_sys_i);
    {wr, rd} = 2'b00;
    rdat = rdata;
    ck(ack === e, "unexpected ack state");
endtask
task wait_on(input int s, input int lim);
    n = 0;
    while (!(s == 0 ? ready : s == 1 ? locked : term) && n < lim) begin
        @(negedge clk_sys_i);
        n++;
    end
endtask
task end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task t_init;
    acc(1, 8'h0a, 8'h55, 0);
    wait_on(0, 200);
    acc(0, 8'h0a, 8'h00, 1);
    ck(rdat === 8'h00, "early write took effect");
    acc(0, 8'h77, 8'h00, 1);
    ck(rdat === 8'h00, "unmapped read");
    $display("t_init done");
endtask
task t_thermal;
    acc(1, 8'h0a, 8'h12, 1);
    ck(wdog === 8'h12, "watchdog speed-up");
    acc(1, 8'hb0, 8'h04, 1);
    acc(1, 8'hb1, 8'h4c, 1);
    acc(0, 8'hb2, 8'h00, 1);
    acc(1, 8'hb2, (rdat & 8'h8f) | 8'h70, 1);
    ck(fixed === 8'h70, "fixed ramp field");
    acc(1, 8'hb1, 8'h4b, 1);
    acc(0, 8'hb2, 8'h00, 1);
    ad = (rdat | 8'h20) + {{4{toff[3]}}, toff};
    acc(1, 8'hb2, ad, 1);
    acc(0, 8'hb2, 8'h00, 1);
    ck(adapt === 8'h23 && rdat === 8'h23, "adaptive ramp value");
    acc(1, 8'hb0, 8'h00, 1);
    acc(1, 8'hb2, 8'h5a, 1);
    acc(0, 8'hb2, 8'h00, 1);
    ck(rdat === 8'h00 && adapt === 8'h23, "window open off the analog page");
    $display("t_thermal done");
endtask
task t_lanes;
    for (int k = 0; k < 3; k++) begin
        acc(1, 8'h20, 8'h01 << k, 1);
        @(negedge clk_sys_i);
        ck(lanes === lane_exp[k], "lane count");
    end
    acc(1, 8'h20, 8'h03, 1);
    acc(0, 8'h20, 8'h00, 1);
    ck(rdat === 8'h04 && lanes === 4'hf, "illegal lane count taken");
    $display("t_lanes done");
endtask
task t_lock;
    bc_up = 1;
    wait_on(1, 2100);
    ck(n >= 1990 && locked === 1'b1, "lock timing");
    acc(0, 8'h21, 8'h00, 1);
    ck(rdat === 8'h01, "status lock bit");
    acc(1, 8'h01, 8'h01, 1);
    ck(locked === 1'b0 && ready === 1'b1 && wdog === 8'h12, "soft reset");
    wait_on(1, 2100);
    ck(locked === 1'b1, "no relock");
    bc_up = 0;
    repeat (8) @(negedge clk_sys_i);
    ck(locked === 1'b0, "lock kept without reference");
    $display("t_lock done");
endtask
task t_term;
    lp = 0;
    wait_on(2, 40);
    ck(n >= 10 && term === 1'b1, "termination on timing");
    acc(0, 8'h21, 8'h00, 1);
    ck(rdat === 8'h02, "status termination bit");
    lp = 1;
    repeat (6) @(negedge clk_sys_i);
    ck(term === 1'b0, "termination left on");
    $display("t_term done");
endtask
task t_pdn;
    // the pin has stood high far longer than 1 ms before this hard reset
    pdn = 0;
    repeat (3 * MS_CYC) @(negedge clk_sys_i);
    ck(ready === 1'b0 && wdog === 8'h00 && lanes === 4'h0, "power down");
    pdn = 1;
    wait_on(0, 100);
    ck(n >= 20 && ready === 1'b1, "init wait");
    acc(0, 8'h20, 8'h00, 1);
    ck(rdat === 8'h04, "lane default");
    $display("t_pdn done");
endtask
initial begin
    repeat (8) @(negedge clk_sys_i);
    rst_i = 0;
    t_init;
    t_thermal;
    t_lanes;
    t_lock;
    t_term;
    t_pdn;
    end_of_test;
end
initial begin
    #200us;
    n_fail++;
    end_of_test;
end
endmodule
